// *** rtl/flash_host_pkg.sv ***
// Shared constants and types for the flash status-polling host controller
package flash_host_pkg;

	// ************************************************************
	// Software register map
	// ************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;

	// Control register fields
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_BYTE_BIT = 2;
	localparam int CTRL_WP_BIT   = 3;

	// Status register fields
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DONE_BIT  = 1;
	localparam int STAT_FAIL_BIT  = 2;
	localparam int STAT_READY_BIT = 3;
	localparam int STAT_TOG2_BIT  = 4;
	localparam int STAT_TMO_BIT   = 5;
	localparam int STAT_BYTE_LSB  = 8;

	// Status byte bit positions on the flash data pins
	localparam int POLL_BIT   = 7;
	localparam int TOG1_BIT   = 6;
	localparam int TMO_BIT    = 5;
	localparam int WINDOW_BIT = 3;
	localparam int TOG2_BIT   = 2;

	// ************************************************************
	// Pin widths and drive patterns
	// ************************************************************
	localparam int ADDR_PINS = 21;
	localparam int DQ_PINS   = 16;
	localparam logic [15:0] OE_WORD    = 16'hFFFF;
	localparam logic [15:0] OE_BYTE_WR = 16'h80FF;
	localparam logic [15:0] OE_BYTE_RD = 16'h8000;
	localparam logic [15:0] OE_NONE    = 16'h0000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_PULSE_NS    = 200;
	localparam int T_ACCESS_NS   = 300;
	localparam int SYNC_LAT      = 3;
	localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC   = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC    = ACC_CYC + SYNC_LAT + 1;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_READ, OP_POLL} op_t;

	typedef struct packed {
		logic [ADDR_PINS-1:0] addr;
		logic                 ceN;
		logic                 oeN;
		logic                 weN;
		logic                 byteN;
		logic                 protectAccelPin;
		logic [DQ_PINS-1:0]   dqOut;
		logic [DQ_PINS-1:0]   dqOe;
	} flash_out_t;

endpackage

// *** rtl/flash_status_host.sv ***
// Host controller that writes, reads and status-polls an asynchronous parallel flash
`timescale 1ns/10ps
module flash_status_host #(
	parameter logic [7:0] RESET_CMD = 8'hF0
) (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        sys_rst,
	// Software register port
	input  wire logic [7:0]                  regAddr,
	input  wire logic [31:0]                 regWdata,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic      [31:0]                 regRdata,
	// Flash pins
	output flash_host_pkg::flash_out_t       flashOut,
	input  wire logic [flash_host_pkg::DQ_PINS-1:0] dqIn,
	input  wire logic                        ready_busy_n
);
	import flash_host_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_END, ST_RD_PULSE, ST_RD_END
	} bus_st_t;

	typedef enum logic [2:0] {
		PS_FIRST, PS_SECOND, PS_RECHECK1, PS_RECHECK2, PS_FINAL, PS_RESET
	} poll_st_t;

	typedef struct packed {
		bus_st_t     st;
		poll_st_t    ps;
		op_t         op;
		logic [3:0]  cnt;
		logic        byteMode;
		logic        wpLevel;
		logic [21:0] addr;
		logic [15:0] wdata;
		logic [7:0]  first;
		logic [15:0] capt;
		logic        done;
		logic        fail;
		logic        tog2;
		logic        tmo;
		logic [3:0]  pollReads;
		logic [31:0] rdata;
		flash_out_t  pins;
	} state_t;

	state_t      s;
	state_t      next_s;
	logic [16:0] settled;
	logic [15:0] word;

	pin_sync #(.W(17)) pin_sync_inst (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pinIn   ({ready_busy_n, dqIn}),
		.settled (settled)
	);

	// Upper lanes float in byte mode, so only the low byte is meaningful
	assign word = s.byteMode ? {8'h00, settled[7:0]} : settled[15:0];

	// ************************************************************
	// Pin drive derived from the next state so outputs leave flops
	// ************************************************************
	function automatic flash_out_t drivePins(state_t x);
		flash_out_t  p;
		logic        wr;
		logic [15:0] wd;
		p                 = '0;
		wr                = (x.st == ST_WR_SETUP) || (x.st == ST_WR_PULSE);
		wd                = (x.ps == PS_RESET) ? {8'h00, RESET_CMD} : x.wdata;
		p.ceN             = !(wr || x.st == ST_RD_PULSE);
		p.oeN             = (x.st != ST_RD_PULSE);
		p.weN             = (x.st != ST_WR_PULSE);
		p.byteN           = !x.byteMode;
		p.protectAccelPin = x.wpLevel;
		if (x.byteMode) begin
			p.addr = x.addr[21:1];
			if (!p.ceN) begin
				p.dqOut       = {x.addr[0], 7'h00, wd[7:0]};
				p.dqOe        = wr ? OE_BYTE_WR : OE_BYTE_RD;
			end
		end else begin
			p.addr = x.addr[20:0];
			if (wr) begin
				p.dqOut = wd;
				p.dqOe  = OE_WORD;
			end
		end
		return p;
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_s       = s;
		next_s.rdata = '0;
		unique case (s.st)
			ST_IDLE: begin
			end
			ST_WR_SETUP: begin
				next_s.st  = ST_WR_PULSE;
				next_s.cnt = '0;
			end
			ST_WR_PULSE: begin
				if (s.cnt == 4'(PULSE_CYC - 1)) begin
					next_s.st = ST_WR_END;
				end else begin
					next_s.cnt = s.cnt + 4'h1;
				end
			end
			ST_WR_END: begin
				next_s.st   = ST_IDLE;
				next_s.done = 1'b1;
				if (s.ps == PS_RESET) begin
					next_s.fail = 1'b1;
				end
			end
			ST_RD_PULSE: begin
				if (s.cnt == 4'(RD_CYC - 1)) begin
					next_s.capt = word;
					next_s.st   = ST_RD_END;
					if (s.pollReads != 4'hF) begin
						next_s.pollReads = s.pollReads + 4'h1;
					end
				end else begin
					next_s.cnt = s.cnt + 4'h1;
				end
			end
			ST_RD_END: begin
				// Chip select goes high here so every read is a separate cycle
				next_s.st  = ST_RD_PULSE;
				next_s.cnt = '0;
				if (s.capt[TOG2_BIT] != s.first[TOG2_BIT] && s.ps != PS_FIRST) begin
					next_s.tog2 = 1'b1;
				end
				if (s.capt[TMO_BIT]) begin
					next_s.tmo = 1'b1;
				end
				if (s.op != OP_POLL || s.ps == PS_FINAL) begin
					next_s.st   = ST_IDLE;
					next_s.done = 1'b1;
				end else begin
					unique case (s.ps)
						PS_FIRST, PS_RECHECK1: begin
							next_s.first = s.capt[7:0];
							next_s.ps    = (s.ps == PS_FIRST) ? PS_SECOND : PS_RECHECK2;
						end
						PS_SECOND, PS_RECHECK2: begin
							next_s.first = s.capt[7:0];
							if (s.capt[TOG1_BIT] == s.first[TOG1_BIT]) begin
								next_s.ps = PS_FINAL;
							end else if (s.ps == PS_RECHECK2) begin
								next_s.ps = PS_RESET;
								next_s.st = ST_WR_SETUP;
							end else if (s.capt[TMO_BIT]) begin
								next_s.ps = PS_RECHECK1;
							end
						end
						default: begin
							next_s.st = ST_IDLE;
						end
					endcase
				end
			end
		endcase

		// Register reads answer in the following cycle only
		if (regRd) begin
			unique case (regAddr)
				REG_CTRL:   next_s.rdata = {28'h000_0000, s.wpLevel, s.byteMode, s.op};
				REG_ADDR:   next_s.rdata = {10'h000, s.addr};
				REG_WDATA:  next_s.rdata = {16'h0000, s.wdata};
				REG_STATUS: begin
					next_s.rdata[STAT_BUSY_BIT]  = (s.st != ST_IDLE);
					next_s.rdata[STAT_DONE_BIT]  = s.done;
					next_s.rdata[STAT_FAIL_BIT]  = s.fail;
					next_s.rdata[STAT_READY_BIT] = settled[16];
					next_s.rdata[STAT_TOG2_BIT]  = s.tog2;
					next_s.rdata[STAT_TMO_BIT]   = s.tmo;
					next_s.rdata[STAT_BYTE_LSB +: 8] = s.capt[7:0];
				end
				REG_RDATA:  next_s.rdata = {16'h0000, s.capt};
				default:    next_s.rdata = '0;
			endcase
		end

		// Settings change only while idle; a start is dropped when busy
		if (regWr && s.st == ST_IDLE) begin
			unique case (regAddr)
				REG_CTRL: begin
					next_s.byteMode = regWdata[CTRL_BYTE_BIT];
					next_s.wpLevel  = regWdata[CTRL_WP_BIT];
					next_s.op       = op_t'(regWdata[CTRL_OP_LSB +: 2]);
					if (op_t'(regWdata[CTRL_OP_LSB +: 2]) != OP_NONE) begin
						next_s.done      = 1'b0;
						next_s.fail      = 1'b0;
						next_s.tog2      = 1'b0;
						next_s.tmo       = 1'b0;
						next_s.pollReads = '0;
						next_s.first     = '0;
						next_s.ps        = PS_FIRST;
						next_s.cnt       = '0;
						next_s.st        = (op_t'(regWdata[CTRL_OP_LSB +: 2]) == OP_WRITE)
						                   ? ST_WR_SETUP : ST_RD_PULSE;
					end
				end
				REG_ADDR:  next_s.addr  = regWdata[21:0];
				REG_WDATA: next_s.wdata = regWdata[15:0];
				default: begin
				end
			endcase
		end

		next_s.pins = drivePins(next_s);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s                      <= '0;
			s.pins.ceN             <= 1'b1;
			s.pins.oeN             <= 1'b1;
			s.pins.weN             <= 1'b1;
			s.pins.byteN           <= 1'b1;
			s.pins.protectAccelPin <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign flashOut = s.pins;
	assign regRdata = s.rdata;

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_poll_addr;
		@(posedge ref_clk) disable iff (sys_rst)
		(s.op == OP_POLL && !s.pins.oeN && !s.byteMode) |-> (s.pins.addr == s.addr[20:0]);
	endproperty
	a_poll_addr: assert property (p_poll_addr)
		else $error("poll read not at programmed address");

	property p_erase_addr_stable;
		@(posedge ref_clk) disable iff (sys_rst)
		(s.op == OP_POLL && !s.pins.oeN) ##1 (!s.pins.oeN) |-> $stable(s.pins.addr);
	endproperty
	a_erase_addr_stable: assert property (p_erase_addr_stable)
		else $error("poll address moved during a status read");

	property p_final_read;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(s.ps == PS_FINAL) |-> ##[1:4] !s.pins.oeN;
	endproperty
	a_final_read: assert property (p_final_read)
		else $error("no extra read after toggling stopped");

	property p_two_reads;
		@(posedge ref_clk) disable iff (sys_rst)
		($rose(s.done) && s.op == OP_POLL && !s.fail) |-> (s.pollReads >= 4'h3);
	endproperty
	a_two_reads: assert property (p_two_reads)
		else $error("poll finished without two compared reads and a final read");

	property p_reset_cmd;
		@(posedge ref_clk) disable iff (sys_rst)
		(s.ps == PS_RESET && !s.pins.weN) |-> (s.pins.dqOut[7:0] == RESET_CMD);
	endproperty
	a_reset_cmd: assert property (p_reset_cmd)
		else $error("reset command value wrong");

	property p_fail_after_reset;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(s.fail) |-> ($past(s.ps) == PS_RESET && $past(s.st) == ST_WR_END);
	endproperty
	a_fail_after_reset: assert property (p_fail_after_reset)
		else $error("failure reported without a reset command write");

	property p_byte_lanes;
		@(posedge ref_clk) disable iff (sys_rst)
		(s.byteMode && !s.pins.ceN) |->
			(s.pins.dqOe[14:8] == 7'h00 && s.pins.dqOe[15] && s.pins.dqOut[15] == s.addr[0]);
	endproperty
	a_byte_lanes: assert property (p_byte_lanes)
		else $error("byte mode lanes driven wrongly");
endmodule // flash_status_host

// *** rtl/pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 17
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// Pins and settled value
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] settled
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
		logic [W-1:0] stage3;
		logic [W-1:0] held;
	} sync_t;

	sync_t s;
	sync_t next_s;

	// Stage one feeds stage two only; the agreement test looks at two and three
	always_comb begin
		next_s        = s;
		next_s.stage1 = pinIn;
		next_s.stage2 = s.stage1;
		next_s.stage3 = s.stage2;
		if (s.stage2 == s.stage3) begin
			next_s.held = s.stage3;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign settled = s.held;
endmodule // pin_sync

// *** verification/flash_device_model.sv ***
// Behavioural flash device that answers the host's program, erase, read and status polls
`timescale 1ns/10ps
module flash_device_model #(
	parameter int         BUSY_READS = 3,
	// Address bits 20:15 of the boot sectors that the protect pin guards here
	parameter logic [5:0] PROT_TOP   = 6'h3F,
	parameter logic [7:0] RESET_CMD  = 8'hF0
) (
	// Host pins
	input  wire flash_host_pkg::flash_out_t flashOut,
	// Test controls
	input  wire logic                       hangOp,
	input  wire logic                       eraseOp,
	// Device outputs
	output logic [15:0]                     dqIn,
	output logic                            ready_busy_n
);
	import flash_host_pkg::*;
	logic [15:0] memWord;
	logic [15:0] lastOut;
	logic [15:0] wrData;
	logic        wrSel;
	logic        wrProt;
	logic        busy;
	logic        tog1;
	logic        tog2;
	logic        tmo;
	logic        erasing;
	logic        readSel;
	int          left;
	initial begin
		{memWord, lastOut, wrData} = '0;
		{wrSel, wrProt, busy, tog1, tog2, tmo, erasing} = '0;
		left = 0;
	end
	assign readSel = !flashOut.ceN && !flashOut.oeN && flashOut.weN;
	// Select and data are latched on the falling strobe: chip select rises with the rising strobe
	always @(negedge flashOut.weN) begin
		wrSel = !flashOut.ceN && flashOut.oeN;
		wrData = flashOut.dqOut;
		wrProt = !flashOut.protectAccelPin && flashOut.addr[20:15] == PROT_TOP;
	end
	always @(posedge flashOut.weN) begin
		if (wrSel && busy && wrData[7:0] == RESET_CMD) begin
			busy = 1'b0;
			tmo = 1'b0;
		end else if (wrSel && !busy) begin
			busy = 1'b1;
			left = BUSY_READS;
			erasing = eraseOp;
			// Protected target: status runs its course, the array is left alone
			if (!wrProt)
				memWord = eraseOp ? 16'hFFFF : wrData;
		end
	end
	always @(posedge readSel) begin
		if (busy) begin
			tog1 = ~tog1;
			if (erasing)
				tog2 = ~tog2;
			if (hangOp)
				tmo = 1'b1;
			else
				left = left - 1;
			if (left == 0)
				busy = 1'b0;
		end
		// Window flag reads 1 only while erasing, so the acceptance window is taken as already expired
		lastOut = busy ? {8'h00, erasing ? 1'b0 : ~memWord[7], tog1, tmo, 1'b0,
			erasing, tog2, 2'b00} : memWord;
	end
	// Unselected data lines show the inverse of the last value, not a held copy
	assign dqIn = readSel ? lastOut : ~lastOut;
	assign ready_busy_n = busy ? 1'b0 : 1'b1;
endmodule // flash_device_model

// *** verification/flash_status_host_bench.sv ***
// Self-checking bench for the flash status-polling host controller
`timescale 1ns/10ps
module flash_status_host_bench;
	import flash_host_pkg::*;
	logic        ref_clk;
	logic        sys_rst;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic        regWr;
	logic        regRd;
	logic [31:0] regRdata;
	flash_out_t  flashOut;
	logic [15:0] dqIn;
	logic        ready_busy_n;
	logic        hangOp;
	logic        eraseOp;
	logic [31:0] s;
	flash_out_t  cap;
	int          fails;
	int          n_checks;

	flash_status_host flash_status_host_inst (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashOut(flashOut),
		.dqIn(dqIn), .ready_busy_n(ready_busy_n));
	flash_device_model flash_device_model_inst (
		.flashOut(flashOut), .hangOp(hangOp), .eraseOp(eraseOp), .dqIn(dqIn),
		.ready_busy_n(ready_busy_n));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Pins as they stand when the write strobe falls
	always @(negedge flashOut.weN) cap = flashOut;

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chkBit(input logic got, input logic exp, input string what);
		chkReg({31'h0, got}, {31'h0, exp}, what);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic runOp(input logic [31:0] ctrl);
		wr(REG_CTRL, ctrl);
		for (int i = 0; i < 400; i++) begin
			rd(REG_STATUS, s);
			if (s[STAT_BUSY_BIT] === 1'b0 && s[STAT_DONE_BIT] === 1'b1)
				return;
		end
		fails++;
		$display("mismatch at %0t: operation never finished", $time);
		finish_test();
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		{sys_rst, regAddr, regWdata, regWr, regRd, hangOp, eraseOp} = '0;
		sys_rst = 1'b1;
		fails = 0;
		n_checks = 0;
		repeat (12) @(posedge ref_clk);
		chkBit(flashOut.ceN & flashOut.oeN & flashOut.weN, 1'b1, "idle strobes");
		chkBit(flashOut.protectAccelPin, 1'b0, "protect pin");
		chkReg(32'(flashOut.dqOe), 32'(OE_NONE), "reset drive");
		sys_rst <= 1'b0;
		rd(8'h20, s);
		chkReg(s, 32'h0000_0000, "unmapped read");
		$display("reset test done");

		wr(REG_ADDR, 32'h0001_2345);
		wr(REG_WDATA, 32'h0000_00A5);
		rd(REG_ADDR, s);
		chkReg(s, 32'h0001_2345, "address readback");
		runOp(32'h0000_0001);
		chkReg(32'(cap.addr), 32'h0001_2345, "write address");
		chkReg(32'(cap.dqOut), 32'h0000_00A5, "write data");
		chkReg(32'(cap.dqOe), 32'(OE_WORD), "word drive");
		chkBit(cap.oeN, 1'b1, "output enable in write");
		// Ready pin reaches the status register only after the synchroniser
		repeat (SYNC_LAT) @(posedge ref_clk);
		rd(REG_STATUS, s);
		chkBit(s[STAT_READY_BIT], 1'b0, "busy pin seen");
		runOp(32'h0000_0003);
		chkBit(s[STAT_FAIL_BIT], 1'b0, "poll fail");
		chkBit(s[STAT_READY_BIT], 1'b1, "ready pin seen");
		chkReg(32'(s[15:8]), 32'h0000_00A5, "final poll byte");
		runOp(32'h0000_0002);
		rd(REG_RDATA, s);
		chkReg(s, 32'h0000_00A5, "array read");
		$display("program test done");

		hangOp <= 1'b1;
		wr(REG_WDATA, 32'h0000_0055);
		runOp(32'h0000_0001);
		runOp(32'h0000_0003);
		hangOp <= 1'b0;
		chkBit(s[STAT_FAIL_BIT], 1'b1, "timeout fail");
		chkBit(s[STAT_TMO_BIT], 1'b1, "timeout seen");
		chkReg(32'(cap.dqOut[7:0]), 32'h0000_00F0, "reset command");
		chkReg(32'(cap.addr), 32'h0001_2345, "reset address");
		$display("timeout test done");

		eraseOp <= 1'b1;
		runOp(32'h0000_0001);
		eraseOp <= 1'b0;
		runOp(32'h0000_0003);
		chkBit(s[STAT_FAIL_BIT], 1'b0, "erase fail");
		chkBit(s[STAT_TOG2_BIT], 1'b1, "second toggle seen");
		chkReg(32'(s[15:8]), 32'h0000_00FF, "erased byte");
		$display("erase test done");

		wr(REG_ADDR, 32'h0000_ABCD);
		wr(REG_WDATA, 32'h0000_003C);
		runOp(32'h0000_000D);
		chkReg(32'(cap.addr), 32'h0000_55E6, "byte address");
		chkReg(32'(cap.dqOe), 32'(OE_BYTE_WR), "byte drive");
		chkBit(cap.dqOut[15], 1'b1, "low address on pin fifteen");
		chkBit(cap.byteN, 1'b0, "byte mode pin");
		chkBit(cap.protectAccelPin, 1'b1, "protect pin high");
		runOp(32'h0000_000F);
		chkReg(32'(s[15:8]), 32'h0000_003C, "byte poll result");
		$display("byte test done");

		wr(REG_ADDR, 32'h001F_8000);
		runOp(32'h0000_0001);
		runOp(32'h0000_0003);
		chkBit(s[STAT_FAIL_BIT], 1'b0, "protected poll fail");
		runOp(32'h0000_0002);
		rd(REG_RDATA, s);
		chkReg(s, 32'h0000_803C, "protected word kept");
		$display("protect test done");
		finish_test();
	end
endmodule // flash_status_host_bench
